//--- hw/ccc_pkg.sv
/*
 * charger control shared constants.
 * assumes one 25 MHz clock on both ends.
 */
package ccc_pkg;
    localparam int CLK_HZ = 25_000_000;
    // frame identifiers, base format
    localparam int ID_W = 11;
    localparam logic [10:0] CTRL_ID = 11'h190;
    localparam logic [10:0] STAT_ID = 11'h191;
    localparam int DATA_W = 64;
    // control frame fields
    localparam int VOLT_LSB = 0;
    localparam int VOLT_W = 20;
    localparam int STAGE_BIT = 20;
    localparam int CLEAR_BIT = 21;
    localparam int CURR_LSB = 32;
    localparam int CURR_W = 18;
    // status frame fields
    localparam int ST_VOLT_LSB = 0;
    localparam int ST_CURR_LSB = 20;
    localparam int ST_OUT_BIT = 40;
    localparam int ST_MODE_BIT = 41;
    localparam int ST_WDOG_BIT = 42;
    localparam int ST_OVP_BIT = 43;
    localparam int ST_OCP_BIT = 44;
    localparam int ST_GEN_BIT = 45;
    // bit rates and clocks per bit
    typedef enum logic [2:0] {
        CCC_RATE_1M = 3'b000,
        CCC_RATE_800K = 3'b001,
        CCC_RATE_500K = 3'b010,
        CCC_RATE_250K = 3'b011,
        CCC_RATE_125K = 3'b100
    } ccc_rate_t;
    localparam logic [7:0] DIV_1M = 8'(CLK_HZ / 1000000);
    localparam logic [7:0] DIV_800K = 8'(CLK_HZ / 800000);
    localparam logic [7:0] DIV_500K = 8'(CLK_HZ / 500000);
    localparam logic [7:0] DIV_250K = 8'(CLK_HZ / 250000);
    localparam logic [7:0] DIV_125K = 8'(CLK_HZ / 125000);
    // timing: 100 ms, 300 ms, 1 ms
    localparam int CTRL_PERIOD_CYC = CLK_HZ / 1000 * 100;
    localparam int WDOG_CYC = CLK_HZ / 1000 * 300;
    localparam int FILT_CYC = CLK_HZ / 1000;
    localparam int STAT_PERIOD_BITS = 1000;
    localparam int PROF_N = 4;
    localparam logic [17:0] RAMP_STEP = 18'h00001;
    typedef enum logic [0:0] {
        CCC_MODE_BUS = 1'b0,
        CCC_MODE_PROFILE = 1'b1
    } ccc_mode_t;
endpackage

//--- hw/ccc_link_if.sv
/*
 * controller to receiver unit link: word-level frames, two pins.
 * assumes one shared clock; frames are one-cycle strobes.
 */
`timescale 1ns/100ps
interface ccc_link_if;
    import ccc_pkg::*;
    logic rx_valid;
    logic [10:0] rx_id;
    logic [63:0] rx_data;
    logic tx_valid;
    logic [10:0] tx_id;
    logic [63:0] tx_data;
    logic charge_request_input;
    logic sleep_input;
    modport receiver_unit (
        input rx_valid, rx_id, rx_data, charge_request_input, sleep_input,
        output tx_valid, tx_id, tx_data
    );
    modport controller (
        output rx_valid, rx_id, rx_data, charge_request_input, sleep_input,
        input tx_valid, tx_id, tx_data
    );
endinterface // ccc_link_if

//--- hw/ccc_pin_filter.sv
/*
 * synchroniser and glitch filter for one pin.
 * assumes an asynchronous pin; level follows after STABLE_CYC stable cycles.
 */
`timescale 1ns/100ps
module ccc_pin_filter #(
    parameter int STABLE_CYC = 25000
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pin,
    output logic level
);
    logic meta_ff;
    logic sync_ff;
    logic level_ff;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    wire differs = sync_ff != level_ff;
    wire done = cnt_ff >= 32'(STABLE_CYC - 1);
    assign nxt_cnt = (differs && !done) ? cnt_ff + 32'h00000001 : 32'h00000000;
    always_ff @(posedge clock) begin
        meta_ff <= pin;
        sync_ff <= meta_ff;
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level_ff <= 1'b0;
            cnt_ff <= 32'h00000000;
        end else begin
            cnt_ff <= nxt_cnt;
            if (differs && done) begin
                level_ff <= sync_ff;
            end
        end
    end
    assign level = level_ff;
endmodule // ccc_pin_filter

//--- hw/ccc_receiver_unit.sv
/*
 * receiver unit: modes, control decode, watchdog, trips, profiles, status.
 * assumes one-cycle frame strobes; the power stage follows the outputs.
 */
// Function
// (RULE1) exactly two modes: bus and profile
// (RULE2) bus mode unless strapped
// (RULE3) base frames with 11-bit identifiers
// (RULE4) 1M default, four other rates
// (RULE5) voltage target bits 0..19, 1 mV
// (RULE6) current down at target voltage
// (RULE7) stage request bit 20; trips clear on off-on
// (RULE8) fault clear bit 21 clears other faults
// (RULE9) clear leaves trips latched
// (RULE10) current limit bits 32..49, 1 mA
// (RULE11) no frames: output off, fault
// (RULE12) controller sends control frame every 100 ms
// (RULE13) four stored profiles, one selected
// (RULE14) controller drives charge request high/low
// (RULE15) profile mode charges while request high
// (RULE16) sleep input high sleeps, under one second
// (RULE17) asleep: no charging, no frames
// (RULE18) controller sleeps unit only when not charging
// (RULE19) profile: commands ignored, status sent
// (RULE20) watchdog count configurable, restarts on frame
// (RULE21) pins synchronised and glitch filtered
`timescale 1ns/100ps
module ccc_receiver_unit
    import ccc_pkg::*;
#(
    parameter int WDOG_CYCLES = WDOG_CYC,
    parameter int FILT_CYCLES = FILT_CYC,
    parameter int STAT_BITS = STAT_PERIOD_BITS
) (
    input wire logic clock,
    input wire logic sys_rst,
    ccc_link_if.receiver_unit link,
    input wire logic cfg_profile_mode,
    input wire logic [2:0] cfg_rate_sel,
    input wire logic [1:0] cfg_profile_sel,
    input wire logic prof_wr,
    input wire logic [1:0] prof_idx,
    input wire logic [19:0] prof_volt,
    input wire logic [17:0] prof_curr,
    input wire logic [19:0] bat_volt,
    input wire logic ovp_event,
    input wire logic ocp_event,
    input wire logic gen_fault_event,
    output logic out_enable,
    output logic [19:0] volt_target,
    output logic [17:0] curr_cmd,
    output logic sleeping,
    output logic profile_mode,
    output logic link_timeout_fault,
    output logic overvoltage_trip,
    output logic overcurrent_trip,
    output logic gen_fault
);
    function automatic logic [7:0] rate_div(input logic [2:0] sel);
        case (sel)
            CCC_RATE_800K: rate_div = DIV_800K;
            CCC_RATE_500K: rate_div = DIV_500K;
            CCC_RATE_250K: rate_div = DIV_250K;
            CCC_RATE_125K: rate_div = DIV_125K;
            default: rate_div = DIV_1M;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins
    logic charge_req;
    logic sleep_req;
    ccc_pin_filter #(.STABLE_CYC(FILT_CYCLES)) u_charge_filt ( // [RULE21]
        .clock(clock),
        .sys_rst(sys_rst),
        .pin(link.charge_request_input),
        .level(charge_req)
    );
    ccc_pin_filter #(.STABLE_CYC(FILT_CYCLES)) u_sleep_filt ( // [RULE21] [RULE16]
        .clock(clock),
        .sys_rst(sys_rst),
        .pin(link.sleep_input),
        .level(sleep_req)
    );

    ////////////////////////////////////////////////////////////////////////
    // mode, captured once after reset release
    ccc_mode_t mode_ff;
    logic cfg_done_ff;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_ff <= CCC_MODE_BUS; // [RULE2]
            cfg_done_ff <= 1'b0;
        end else if (!cfg_done_ff) begin
            mode_ff <= cfg_profile_mode ? CCC_MODE_PROFILE : CCC_MODE_BUS; // [RULE1]
            cfg_done_ff <= 1'b1;
        end
    end
    wire in_bus = mode_ff == CCC_MODE_BUS;

    ////////////////////////////////////////////////////////////////////////
    // control frame decode
    wire frame_ok = link.rx_valid && link.rx_id == CTRL_ID && !sleep_req; // [RULE3] [RULE17]
    wire ctrl_hit = frame_ok && in_bus; // [RULE19]
    wire new_stage = link.rx_data[STAGE_BIT]; // [RULE7]
    wire new_clear = link.rx_data[CLEAR_BIT]; // [RULE8]
    logic [19:0] bus_volt_ff;
    logic [17:0] bus_curr_ff;
    logic stage_ff;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_volt_ff <= 20'h00000;
            bus_curr_ff <= 18'h00000;
            stage_ff <= 1'b0;
        end else if (ctrl_hit) begin
            bus_volt_ff <= link.rx_data[VOLT_LSB +: VOLT_W]; // [RULE5]
            bus_curr_ff <= link.rx_data[CURR_LSB +: CURR_W]; // [RULE10]
            stage_ff <= new_stage;
        end
    end
    // off-on edge re-arms trips
    wire stage_rise = ctrl_hit && new_stage && !stage_ff; // [RULE7]

    ////////////////////////////////////////////////////////////////////////
    // watchdog held at zero in profile mode and asleep
    logic [31:0] wdog_ff;
    logic [31:0] nxt_wdog;
    wire wdog_expire = in_bus && !sleep_req && wdog_ff >= 32'(WDOG_CYCLES - 1);
    assign nxt_wdog = (ctrl_hit || !in_bus || sleep_req || wdog_expire) ? 32'h00000000
        : wdog_ff + 32'h00000001; // [RULE20]
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wdog_ff <= 32'h00000000;
        end else begin
            wdog_ff <= nxt_wdog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // faults; set beats clear
    logic wdog_flt_ff;
    logic ovp_ff;
    logic ocp_ff;
    logic gen_ff;
    wire clear_hit = ctrl_hit && new_clear;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wdog_flt_ff <= 1'b0;
            ovp_ff <= 1'b0;
            ocp_ff <= 1'b0;
            gen_ff <= 1'b0;
        end else begin
            wdog_flt_ff <= wdog_expire || (wdog_flt_ff && !clear_hit); // [RULE11] [RULE8]
            gen_ff <= gen_fault_event || (gen_ff && !clear_hit); // [RULE8]
            ovp_ff <= ovp_event || (ovp_ff && !stage_rise); // [RULE9] [RULE7]
            ocp_ff <= ocp_event || (ocp_ff && !stage_rise); // [RULE9] [RULE7]
        end
    end
    wire any_fault = wdog_flt_ff || ovp_ff || ocp_ff || gen_ff;

    ////////////////////////////////////////////////////////////////////////
    // profile table
    logic [19:0] prof_v_mem [PROF_N];
    logic [17:0] prof_i_mem [PROF_N];
    always_ff @(posedge clock) begin
        if (prof_wr) begin
            prof_v_mem[prof_idx] <= prof_volt; // [RULE13]
            prof_i_mem[prof_idx] <= prof_curr;
        end
    end
    wire [19:0] sel_volt = in_bus ? bus_volt_ff : prof_v_mem[cfg_profile_sel]; // [RULE13]
    wire [17:0] sel_curr = in_bus ? bus_curr_ff : prof_i_mem[cfg_profile_sel];

    ////////////////////////////////////////////////////////////////////////
    // output enable and current regulation
    wire want_on = in_bus ? stage_ff : charge_req; // [RULE15]
    wire nxt_out = want_on && !any_fault && !sleep_req && !wdog_expire; // [RULE11] [RULE17]
    logic out_ff;
    logic [19:0] volt_ff;
    logic [17:0] curr_ff;
    logic [17:0] nxt_curr;
    wire at_target = bat_volt >= sel_volt;
    logic bit_tick;
    always_comb begin
        nxt_curr = sel_curr;
        if (!nxt_out) begin
            nxt_curr = 18'h00000;
        end else if (at_target) begin
            // one step down per bit tick
            nxt_curr = curr_ff;
            if (bit_tick && curr_ff != 18'h00000) begin
                nxt_curr = curr_ff - RAMP_STEP; // [RULE6]
            end
        end else if (curr_ff > sel_curr) begin
            nxt_curr = sel_curr; // [RULE10]
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_ff <= 1'b0;
            volt_ff <= 20'h00000;
            curr_ff <= 18'h00000;
        end else begin
            out_ff <= nxt_out;
            volt_ff <= sel_volt;
            curr_ff <= nxt_curr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit-rate divider and periodic status frame
    logic [7:0] div_ff;
    logic [15:0] bits_ff;
    wire [7:0] div_top = rate_div(cfg_rate_sel); // [RULE4]
    assign bit_tick = div_ff >= div_top - 8'h01;
    wire stat_due = bit_tick && bits_ff >= 16'(STAT_BITS - 1);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_ff <= 8'h00;
            bits_ff <= 16'h0000;
        end else begin
            div_ff <= bit_tick ? 8'h00 : div_ff + 8'h01;
            if (stat_due) begin
                bits_ff <= 16'h0000;
            end else if (bit_tick) begin
                bits_ff <= bits_ff + 16'h0001;
            end
        end
    end
    logic tx_valid_ff;
    logic [63:0] tx_data_ff;
    logic [63:0] stat_word;
    always_comb begin
        stat_word = 64'h0000000000000000;
        stat_word[ST_VOLT_LSB +: VOLT_W] = volt_ff;
        stat_word[ST_CURR_LSB +: CURR_W] = curr_ff;
        stat_word[ST_OUT_BIT] = out_ff;
        stat_word[ST_MODE_BIT] = mode_ff;
        stat_word[ST_WDOG_BIT] = wdog_flt_ff;
        stat_word[ST_OVP_BIT] = ovp_ff;
        stat_word[ST_OCP_BIT] = ocp_ff;
        stat_word[ST_GEN_BIT] = gen_ff;
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 64'h0000000000000000;
        end else begin
            tx_valid_ff <= stat_due && !sleep_req; // [RULE19] [RULE17]
            // payload moves only with a sent frame
            if (stat_due && !sleep_req) begin
                tx_data_ff <= stat_word;
            end
        end
    end
    assign link.tx_valid = tx_valid_ff;
    assign link.tx_id = STAT_ID; // [RULE3]
    assign link.tx_data = tx_data_ff;

    assign out_enable = out_ff;
    assign volt_target = volt_ff;
    assign curr_cmd = curr_ff;
    assign sleeping = sleep_req;
    assign profile_mode = !in_bus;
    assign link_timeout_fault = wdog_flt_ff;
    assign overvoltage_trip = ovp_ff;
    assign overcurrent_trip = ocp_ff;
    assign gen_fault = gen_ff;
endmodule // ccc_receiver_unit

//--- hw/ccc_controller.sv
/*
 * controller end: control frames, pins, status capture.
 * assumes the receiver unit on the same clock.
 */
`timescale 1ns/100ps
module ccc_controller
    import ccc_pkg::*;
#(
    parameter int PERIOD_CYCLES = CTRL_PERIOD_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    ccc_link_if.controller link,
    input wire logic send_enable,
    input wire logic cmd_load,
    input wire logic [19:0] cmd_volt,
    input wire logic [17:0] cmd_curr,
    input wire logic cmd_stage,
    input wire logic cmd_clear,
    input wire logic charge_req,
    input wire logic sleep_req,
    output logic stat_valid,
    output logic [63:0] stat_data,
    output logic unit_charging
);
    logic [63:0] ctrl_ff;
    logic clear_pend_ff;
    logic [31:0] per_ff;
    logic rx_valid_ff;
    logic [63:0] rx_data_ff;
    logic stat_valid_ff;
    logic [63:0] stat_ff;
    logic sleep_ff;
    wire due = send_enable && per_ff >= 32'(PERIOD_CYCLES - 1); // [RULE12]
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_ff <= 64'h0000000000000000;
            clear_pend_ff <= 1'b0;
            per_ff <= 32'h00000000;
            rx_valid_ff <= 1'b0;
            rx_data_ff <= 64'h0000000000000000;
        end else begin
            if (cmd_load) begin
                ctrl_ff[VOLT_LSB +: VOLT_W] <= cmd_volt; // [RULE5]
                ctrl_ff[CURR_LSB +: CURR_W] <= cmd_curr; // [RULE10]
                ctrl_ff[STAGE_BIT] <= cmd_stage; // [RULE7]
            end
            // clear goes in one frame only
            clear_pend_ff <= (cmd_load && cmd_clear) || (clear_pend_ff && !due);
            per_ff <= (due || !send_enable) ? 32'h00000000 : per_ff + 32'h00000001;
            rx_valid_ff <= due;
            if (due) begin
                rx_data_ff <= ctrl_ff | (64'(clear_pend_ff) << CLEAR_BIT); // [RULE8]
            end
        end
    end
    wire stat_hit = link.tx_valid && link.tx_id == STAT_ID; // [RULE3]
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat_valid_ff <= 1'b0;
            stat_ff <= 64'h0000000000000000;
            sleep_ff <= 1'b0;
        end else begin
            stat_valid_ff <= stat_hit;
            if (stat_hit) begin
                stat_ff <= link.tx_data;
            end
            // sleep only from standby
            sleep_ff <= sleep_req && (sleep_ff || !stat_ff[ST_OUT_BIT]); // [RULE18]
        end
    end
    assign link.rx_valid = rx_valid_ff;
    assign link.rx_id = CTRL_ID;
    assign link.rx_data = rx_data_ff;
    assign link.charge_request_input = charge_req; // [RULE14]
    assign link.sleep_input = sleep_ff;
    assign stat_valid = stat_valid_ff;
    assign stat_data = stat_ff;
    assign unit_charging = stat_ff[ST_OUT_BIT];
endmodule // ccc_controller

//--- tb/ccc_link_sva.sv
/*
 * link assertions on plain signals.
 * assumes one clock, sys_rst synchronous active high.
 */
`timescale 1ns/100ps
module ccc_link_sva
    import ccc_pkg::*;
#(
    parameter int WDOG_CYCLES = 200,
    parameter int FILT_CYCLES = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic rx_valid,
    input wire logic [10:0] rx_id,
    input wire logic [63:0] rx_data,
    input wire logic tx_valid,
    input wire logic [10:0] tx_id,
    input wire logic [63:0] tx_data,
    input wire logic charge_request_input,
    input wire logic sleep_input
);
    logic [15:0] gap_ff;
    logic [15:0] nxt_gap;
    logic [15:0] slp_ff;
    logic [15:0] nxt_slp;
    wire gap_full = &gap_ff;
    wire slp_full = &slp_ff;
    // the unit's watchdog is held at zero asleep
    assign nxt_gap = (rx_valid || sleep_input) ? 16'h0000 : gap_ff + 16'(!gap_full);
    assign nxt_slp = sleep_input ? slp_ff + 16'(!slp_full) : 16'h0000;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gap_ff <= 16'h0000;
            slp_ff <= 16'h0000;
        end else begin
            gap_ff <= nxt_gap;
            slp_ff <= nxt_slp;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_quiet;
        !tx_valid [*8];
    endsequence
    // slack: filter delay on wake
    sequence s_link_lost;
        tx_valid && !tx_data[ST_MODE_BIT] && (gap_ff > 16'(WDOG_CYCLES + FILT_CYCLES + 8));
    endsequence
    chk_ctrl_id: assert property (rx_valid |-> rx_id == CTRL_ID)
        else $error("bad control id");
    chk_stat_id: assert property (tx_valid |-> tx_id == STAT_ID)
        else $error("bad status id");
    chk_stat_space: assert property (tx_valid |=> s_quiet)
        else $error("status frames too close");
    chk_stat_hold: assert property (!tx_valid |-> $stable(tx_data))
        else $error("status payload moved");
    chk_sleep_quiet: assert property (slp_ff > 16'(FILT_CYCLES + 8) |-> !tx_valid)
        else $error("frame while asleep");
    chk_sleep_standby: assert property ($rose(sleep_input) |-> !$past(tx_data[ST_OUT_BIT], 2))
        else $error("sleep while charging");
    chk_wdog_trip: assert property (s_link_lost |-> tx_data[ST_WDOG_BIT] && !tx_data[ST_OUT_BIT])
        else $error("watchdog did not trip");
    chk_prof_no_wdog: assert property (tx_valid && tx_data[ST_MODE_BIT] |-> !tx_data[ST_WDOG_BIT])
        else $error("watchdog fault in profile mode");
endmodule // ccc_link_sva

//--- tb/charger_can_control_bench.sv
/*
 * self-checking bench for both ends over ccc_link_if.
 * assumes 25 MHz; long counts shortened by parameters.
 */
`timescale 1ns/100ps
module charger_can_control_bench
    import ccc_pkg::*;
;
    localparam int WDOG = 200;
    localparam int FILT = 4;
    localparam int SBITS = 8;
    localparam int PER = 50;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_profile_mode = 1'b0;
    logic [2:0] cfg_rate_sel = 3'h0;
    logic [1:0] cfg_profile_sel = 2'h0;
    logic prof_wr = 1'b0;
    logic [1:0] prof_idx = 2'h0;
    logic [19:0] prof_volt = 20'h00000;
    logic [17:0] prof_curr = 18'h00000;
    logic [19:0] bat_volt = 20'h00000;
    logic [2:0] ev = 3'h0;
    logic send_enable = 1'b0;
    logic cmd_load = 1'b0;
    logic [19:0] cmd_volt = 20'h00000;
    logic [17:0] cmd_curr = 18'h00000;
    logic cmd_stage = 1'b0;
    logic cmd_clear = 1'b0;
    logic charge_req = 1'b0;
    logic sleep_req = 1'b0;
    logic out_enable, sleeping, profile_mode, link_timeout_fault, overvoltage_trip, overcurrent_trip, gen_fault;
    logic [19:0] volt_target;
    logic [17:0] curr_cmd;
    logic stat_valid, unit_charging;
    logic [63:0] stat_data;
    logic [63:0] last_rx;
    int err_count = 0;
    int check_count = 0;
    int divs [6] = '{int'(DIV_1M), int'(DIV_800K), int'(DIV_500K), int'(DIV_250K), int'(DIV_125K), int'(DIV_1M)};
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    always #20 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    ccc_link_if link ();
    ccc_controller #(.PERIOD_CYCLES(PER)) i_ccc_controller (.clock(clock), .sys_rst(sys_rst),
        .link(link.controller), .send_enable(send_enable), .cmd_load(cmd_load), .cmd_volt(cmd_volt),
        .cmd_curr(cmd_curr), .cmd_stage(cmd_stage), .cmd_clear(cmd_clear), .charge_req(charge_req),
        .sleep_req(sleep_req), .stat_valid(stat_valid), .stat_data(stat_data), .unit_charging(unit_charging));
    ccc_receiver_unit #(.WDOG_CYCLES(WDOG), .FILT_CYCLES(FILT), .STAT_BITS(SBITS)) i_ccc_receiver_unit (
        .clock(clock), .sys_rst(sys_rst), .link(link.receiver_unit), .cfg_profile_mode(cfg_profile_mode),
        .cfg_rate_sel(cfg_rate_sel), .cfg_profile_sel(cfg_profile_sel), .prof_wr(prof_wr), .prof_idx(prof_idx),
        .prof_volt(prof_volt), .prof_curr(prof_curr), .bat_volt(bat_volt), .ovp_event(ev[0]),
        .ocp_event(ev[1]), .gen_fault_event(ev[2]), .out_enable(out_enable), .volt_target(volt_target),
        .curr_cmd(curr_cmd), .sleeping(sleeping), .profile_mode(profile_mode),
        .link_timeout_fault(link_timeout_fault), .overvoltage_trip(overvoltage_trip),
        .overcurrent_trip(overcurrent_trip), .gen_fault(gen_fault));
    ccc_link_sva #(.WDOG_CYCLES(WDOG), .FILT_CYCLES(FILT)) i_ccc_link_sva (.clock(clock), .sys_rst(sys_rst),
        .rx_valid(link.rx_valid), .rx_id(link.rx_id), .rx_data(link.rx_data), .tx_valid(link.tx_valid),
        .tx_id(link.tx_id), .tx_data(link.tx_data), .charge_request_input(link.charge_request_input),
        .sleep_input(link.sleep_input));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic do_reset(input logic pm);
        cfg_profile_mode = pm;
        sys_rst = 1'b1;
        cyc(4);
        sys_rst = 1'b0;
        cyc(2);
    endtask
    // wait n frames, keep last payload
    task automatic frames(input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            t = 0;
            cyc(1);
            while (link.rx_valid !== 1'b1 && t < 3 * PER) begin
                cyc(1);
                t++;
            end
            check("frame_seen", link.rx_valid, 1'b1);
            last_rx = link.rx_data;
        end
        cyc(3);
    endtask
    // first frame may carry the old payload
    task automatic load(input logic [19:0] v, input logic [17:0] c, input logic st, input logic cl);
        cmd_volt = v;
        cmd_curr = c;
        cmd_stage = st;
        cmd_clear = cl;
        cmd_load = 1'b1;
        cyc(1);
        cmd_load = 1'b0;
        frames(2);
    endtask
    task automatic stat_gap(output int g);
        g = 0;
        while (link.tx_valid !== 1'b1 && g < 4000) begin
            cyc(1);
            g++;
        end
        g = 0;
        cyc(1);
        while (link.tx_valid !== 1'b1 && g < 4000) begin
            cyc(1);
            g++;
        end
        check("stat_seen", link.tx_valid, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_bus();
        check("profile_mode", profile_mode, 1'b0);
        send_enable = 1'b1;
        load(20'h0abcd, 18'h12345, 1'b1, 1'b0);
        check("wire_volt", last_rx[VOLT_LSB +: VOLT_W], 20'h0abcd);
        check("wire_stage", last_rx[STAGE_BIT], 1'b1);
        check("wire_curr", last_rx[CURR_LSB +: CURR_W], 18'h12345);
        check("volt_target", volt_target, 20'h0abcd);
        check("curr_cmd", curr_cmd, 18'h12345);
        check("out_enable", out_enable, 1'b1);
    endtask
    task automatic t_rates();
        int g;
        for (int i = 0; i < 6; i++) begin
            cfg_rate_sel = codes[i];
            stat_gap(g);
            stat_gap(g);
            check("stat_period", 64'(g + 1), 64'(SBITS * divs[i]));
        end
        cfg_rate_sel = 3'h0;
        cyc(2);
        check("unit_charging", unit_charging, 1'b1);
    endtask
    task automatic t_regulate();
        load(20'h01000, 18'h00010, 1'b1, 1'b0);
        bat_volt = 20'h01000;
        cyc(3 * DIV_1M);
        check("curr_ramp", (curr_cmd < 18'h00010) && (curr_cmd > 18'h0000b), 1'b1);
        cyc(20 * DIV_1M);
        check("curr_zero", curr_cmd, 18'h00000);
        bat_volt = 20'h00fff;
        cyc(4);
        check("curr_limit", curr_cmd, 18'h00010);
    endtask
    task automatic t_trips();
        ev = 3'h7;
        cyc(1);
        ev = 3'h0;
        cyc(3);
        check("trips_set", {overvoltage_trip, overcurrent_trip, gen_fault, out_enable}, 4'he);
        load(20'h01000, 18'h00010, 1'b1, 1'b1);
        check("clear_keeps", {overvoltage_trip, overcurrent_trip, gen_fault, out_enable}, 4'hc);
        load(20'h01000, 18'h00010, 1'b0, 1'b0);
        load(20'h01000, 18'h00010, 1'b1, 1'b0);
        check("stage_cycle", {overvoltage_trip, overcurrent_trip, out_enable}, 3'h1);
    endtask
    task automatic t_wdog();
        send_enable = 1'b0;
        cyc(WDOG - PER - 10);
        check("wdog_early", link_timeout_fault, 1'b0);
        cyc(PER + 30);
        check("wdog_trip", {link_timeout_fault, out_enable}, 2'h2);
        send_enable = 1'b1;
        load(20'h01000, 18'h00010, 1'b1, 1'b1);
        check("wdog_clear", {link_timeout_fault, out_enable}, 2'h1);
    endtask
    task automatic t_sleep();
        int n;
        load(20'h01000, 18'h00010, 1'b0, 1'b0);
        stat_gap(n);
        cyc(3);
        sleep_req = 1'b1;
        cyc(2);
        sleep_req = 1'b0;
        cyc(FILT + 8);
        check("sleep_glitch", sleeping, 1'b0);
        sleep_req = 1'b1;
        cyc(FILT + 8);
        check("sleep_on", sleeping, 1'b1);
        load(20'h01000, 18'h00010, 1'b1, 1'b0);
        n = 0;
        repeat (3 * SBITS * DIV_1M) begin
            cyc(1);
            n += int'(link.tx_valid === 1'b1);
        end
        check("asleep_quiet", {32'(n), 31'h0, out_enable}, 64'h0);
        sleep_req = 1'b0;
        cyc(FILT + 8);
        check("sleep_off", sleeping, 1'b0);
        frames(2);
        check("awake_out", out_enable, 1'b1);
    endtask
    task automatic t_profile();
        int g;
        for (int i = 0; i < PROF_N; i++) begin
            prof_wr = 1'b1;
            prof_idx = 2'(i);
            prof_volt = 20'h10000 + 20'(i);
            prof_curr = 18'h00100 + 18'(i);
            cyc(1);
        end
        prof_wr = 1'b0;
        do_reset(1'b1);
        check("profile_mode", profile_mode, 1'b1);
        charge_req = 1'b1;
        cyc(FILT + 8);
        check("pin_charge", link.charge_request_input, 1'b1);
        for (int i = 0; i < PROF_N; i++) begin
            cfg_profile_sel = 2'(i);
            cyc(3);
            check("prof_targets", {volt_target, curr_cmd, out_enable}, {20'h10000 + 20'(i), 18'h00100 + 18'(i), 1'b1});
        end
        load(20'h00001, 18'h00001, 1'b0, 1'b0);
        check("prof_ignores", {volt_target, out_enable}, {20'h10003, 1'b1});
        stat_gap(g);
        cyc(2);
        check("prof_status", stat_data[ST_MODE_BIT], 1'b1);
        charge_req = 1'b0;
        cyc(FILT + 8);
        check("prof_stop", out_enable, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clock);
        err_count++;
        give_verdict();
    end
    initial begin
        do_reset(1'b0);
        t_bus();
        t_rates();
        t_regulate();
        t_trips();
        t_wdog();
        t_sleep();
        t_profile();
        give_verdict();
    end
endmodule // charger_can_control_bench
